// *** hdl/hsc_cfg_map.svh ***
// hsc_cfg_map.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the configuration register bank; definitions only
`ifndef HSC_CFG_MAP_SVH
`define HSC_CFG_MAP_SVH

`define HSC_ADDR_GATE_CONTROL    8'h0a
`define HSC_ADDR_RETRY_POLICY    8'h0b
`define HSC_ADDR_CURRENT_LIMIT   8'h0d
`define HSC_ADDR_FET_CHECK       8'h0e
`define HSC_ADDR_METER_BCAST     8'h0f
`define HSC_ADDR_GOOD_PIN_MODE   8'h10
`define HSC_ADDR_PIN_OUT_ADC     8'h11
`define HSC_ADDR_AUX_PIN         8'h12
`define HSC_ADDR_ADC_SEL_A       8'h13
`define HSC_ADDR_ADC_SEL_B       8'h14
`define HSC_ADDR_FAULT_MASK      8'h15

`define HSC_RST_GATE_CONTROL     8'hdb
`define HSC_RST_RETRY_POLICY     8'h03
`define HSC_RST_CURRENT_LIMIT    8'h0c
`define HSC_RST_FET_CHECK        8'h00
`define HSC_RST_METER_BCAST      8'h00
`define HSC_RST_GOOD_PIN_MODE    8'h00
`define HSC_RST_PIN_OUT_ADC      8'h04
`define HSC_RST_AUX_PIN          8'hf0
`define HSC_RST_ADC_SEL_A        8'hff
`define HSC_RST_ADC_SEL_B        8'h0f
`define HSC_RST_FAULT_MASK       8'h00

// gate_control fields
`define HSC_GC_ON       7
`define HSC_GC_SLOPE    6
`define HSC_GC_TMR      5
`define HSC_GC_FETOFF   4
`define HSC_GC_PGCLR    3
`define HSC_GC_LIMIND   2
`define HSC_GC_MASS     1
`define HSC_GC_PAGE     0
// retry_policy fields
`define HSC_RP_EXT      7
`define HSC_RP_PGI      6
`define HSC_RP_FET_HI   5
`define HSC_RP_FET_LO   4
`define HSC_RP_OC_HI    3
`define HSC_RP_OC_LO    2
`define HSC_RP_UV       1
`define HSC_RP_OV       0
// current_limit_config fields
`define HSC_CL_CODE_HI  7
`define HSC_CL_CODE_LO  4
`define HSC_CL_FB_HI    3
`define HSC_CL_FB_LO    2
`define HSC_CL_FBOFF    1
`define HSC_CL_LOAD_POWER_FOLDBACK_ENABLE     0
// fet_check_timing_config fields
`define HSC_FC_DTH_HI   7
`define HSC_FC_DTH_LO   6
`define HSC_FC_FLT_HI   5
`define HSC_FC_FLT_LO   4
`define HSC_FC_COOL_HI  3
`define HSC_FC_COOL_LO  1
`define HSC_FC_POR      0
// meter_broadcast_config fields
`define HSC_MB_EXTOFF   7
`define HSC_MB_VSEL     6
`define HSC_MB_FAST     5
`define HSC_MB_BC_HI    4
`define HSC_MB_BC_LO    3
`define HSC_MB_TICKA    2
`define HSC_MB_METERA   1
`define HSC_MB_INTI     0
// pin_output_adc_rate fields
`define HSC_PO_ADC_HI   2
`define HSC_PO_ADC_LO   0

// base cooldown 0.512 s, fet filter base 0.256 s, at 40 MHz
`define HSC_COOL_BASE_MS      512
`define HSC_FILT_BASE_MS      256
`define HSC_CLK_KHZ           40000
`define HSC_COOL_BASE_CYC     (`HSC_COOL_BASE_MS * `HSC_CLK_KHZ)
`define HSC_FILT_BASE_CYC     (`HSC_FILT_BASE_MS * `HSC_CLK_KHZ)

`endif

// *** hdl/hsc_cfg_pkg.sv ***
// hsc_cfg_pkg: types of the configuration register bank
// assumes: used with hsc_cfg_map.svh
package hsc_cfg_pkg;
	typedef logic [7:0] hsc_byte_t;

	typedef enum logic [1:0] {
		HSC_PG_ACT_LOW  = 2'b00,
		HSC_PG_ACT_HIGH = 2'b01,
		HSC_PG_GP_OUT   = 2'b10,
		HSC_PG_GP_IN    = 2'b11
	} hsc_pin_mode_e;

	typedef enum logic [1:0] {
		HSC_RETRY_NONE  = 2'b00,
		HSC_RETRY_ONE   = 2'b01,
		HSC_RETRY_SEVEN = 2'b10,
		HSC_RETRY_ALL   = 2'b11
	} hsc_retry_e;

	typedef struct packed {
		hsc_byte_t gate_control;
		hsc_byte_t retry_policy;
		hsc_byte_t current_limit_config;
		hsc_byte_t fet_check_timing_config;
		hsc_byte_t meter_broadcast_config;
		hsc_byte_t power_good_pin_mode;
		hsc_byte_t pin_output_adc_rate;
		hsc_byte_t aux_pin_config;
		hsc_byte_t adc_channel_select_a;
		hsc_byte_t adc_channel_select_b;
		hsc_byte_t fault_interrupt_mask;
		hsc_byte_t rd_data;
		logic      rd_valid;
		logic      wr_ack;
	} hsc_state_s;
endpackage : hsc_cfg_pkg

// *** hdl/hsc_cfg_regs.sv ***
// hsc_cfg_regs: configuration register bank of the hot swap controller
// assumes: the serial bus engine presents one byte access per cycle on the
// documented register offsets; analog blocks sample the decoded control levels
`timescale 1ns/1ps
`default_nettype none
`include "hsc_cfg_map.svh"

// Summary of operation
// - gate bit on turns transistor on, off turns off; resets to on.
// - slope bit selects voltage-slope inrush instead of current-limit inrush.
// - transistor-fault shutoff bit, default one, turns transistor off after fault.
// - clear source bit: one clears power-good on low output, zero on turnoff.
// - limit indicator bit makes second good pin show inverted limit engagement.
// - mass writes and page protocols honoured only while their bits are set.
// - external and good-input faults retry forever at one, latch at zero.
// - undervoltage and overvoltage retry forever at one (default), latch at zero.
// - two-bit retry counts give zero, one, seven or unlimited retries.
// - cooldown before retry is 0.512 s doubled per code step.
// - limit code sets 15 mV plus 1 mV per step, fast twice that.
// - foldback code picks 100, 50, 20, 10 percent; separate post-startup disable.
// - load power foldback after startup when its bit is set.
// - drain threshold code selects 72, 102, 143 or 203 mV.
// - filter delay code selects 0.256, 0.512, 1.02 or 2.05 s.
// - power-on indicator clears on reset; host sets it to one.
// - external fault shutoff bit turns transistor off after external fault.
// - power select chooses drain or input voltage for power multiply.
// - broadcast rate code; two slowest rates barred with 8-bit resolution.
// - meter mode integrates current or power; overflow alert enables.
// - good pin field: active low, active high, output, input.
// - aux pin is input when its bit is one, else drives data bit.
// - adc measures a channel only while its select bit is set.
// - adc code sets resolution, rate and sampling clock; xx1 gives 16 bits.
module hsc_cfg_regs
	import hsc_cfg_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// register access from the serial bus engine
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [7:0]  REG_WDATA_I,
	input  wire logic        MASS_WR_I,
	output logic      [7:0]  REG_RDATA_O,
	output logic             REG_RVALID_O,
	output logic             REG_WACK_O,
	output logic             MASS_WR_EN_O,
	output logic             PAGE_RW_EN_O,
	// gate and inrush control
	output logic             GATE_ON_O,
	output logic             SLOPE_INRUSH_O,
	output logic             TMR_PULLDOWN_OFF_O,
	output logic             FET_FAULT_SHUTOFF_O,
	output logic             EXT_FAULT_SHUTOFF_O,
	output logic             GOOD_CLEAR_BY_VOUT_O,
	// retry policy
	output logic             EXT_FAULT_AUTORETRY_O,
	output logic             GOOD_INPUT_AUTORETRY_O,
	output logic             UV_AUTORETRY_O,
	output logic             OV_AUTORETRY_O,
	output logic      [3:0]  FET_RETRY_LIMIT_O,
	output logic      [3:0]  OVERCURRENT_RETRY_COUNT_LIMIT_O,
	output logic      [31:0] COOLDOWN_CYC_O,
	// current limit
	output logic      [3:0]  LIMIT_MV_O,
	output logic      [5:0]  FAST_LIMIT_MV_O,
	output logic      [1:0]  FOLDBACK_CODE_O,
	output logic             POST_STARTUP_FOLDBACK_OFF_O,
	output logic             LOAD_POWER_FOLDBACK_O,
	// transistor fault check
	output logic      [1:0]  DRAIN_THRESHOLD_CODE_O,
	output logic      [31:0] FILTER_CYC_O,
	output logic             POWER_ON_INDICATOR_O,
	// metering and broadcast
	output logic             POWER_VOLTAGE_SELECT_O,
	output logic      [1:0]  BROADCAST_RATE_CODE_O,
	output logic             METER_INTEGRATE_CURRENT_O,
	output logic             TICK_OVF_ALERT_EN_O,
	output logic             METER_OVF_ALERT_EN_O,
	// good pins
	input  wire logic        LIMIT_ACTIVE_I,
	input  wire logic [3:0]  GOOD_FUNC_I,
	output logic      [3:0]  GOOD_PIN_O,
	output logic      [3:0]  GOOD_PIN_OE_O,
	// aux pins
	output logic      [3:0]  AUX_PIN_O,
	output logic      [3:0]  AUX_PIN_OE_O,
	// adc and fault interrupt mask
	output logic      [11:0] ADC_INPUT_SELECT_O,
	output logic      [4:0]  ADC_BITS_O,
	output logic      [1:0]  ADC_SAMPLE_DIV_O,
	output logic      [7:0]  FAULT_INTERRUPT_MASK_O
);

	hsc_state_s st;
	hsc_state_s next_st;

	// output-level registers driven from flip-flops, with their combinational next values
	logic [3:0]  good_pin;
	logic [3:0]  good_oe;
	logic [3:0]  next_good_pin;
	logic [3:0]  next_good_oe;
	logic [31:0] cool_cyc;
	logic [31:0] filt_cyc;
	logic [31:0] next_cool_cyc;
	logic [31:0] next_filt_cyc;
	logic [1:0]  bc_code;
	logic [1:0]  next_bc_code;

	function automatic logic [3:0] retry_limit(input logic [1:0] code);
		unique case (hsc_retry_e'(code))
			HSC_RETRY_NONE:  retry_limit = 4'h0;
			HSC_RETRY_ONE:   retry_limit = 4'h1;
			HSC_RETRY_SEVEN: retry_limit = 4'h7;
			HSC_RETRY_ALL:   retry_limit = 4'hf;
		endcase
	endfunction : retry_limit

	// adc code to resolution bits
	function automatic logic [4:0] adc_bits(input logic [2:0] code);
		if (code[0]) begin
			adc_bits = 5'h10;
		end else begin
			adc_bits = 5'(5'h08 + {code[2:1], 1'b0});
		end
	endfunction : adc_bits

	logic        wr_ok;
	logic [7:0]  wd;
	logic [2:0]  adc_code;
	logic [1:0]  bc_req;

	always_comb begin
		next_st          = st;
		next_st.rd_valid = 1'b0;
		next_st.wr_ack   = 1'b0;
		wd               = REG_WDATA_I;
		// mass writes only pass while enabled
		wr_ok            = REG_WR_I && (!MASS_WR_I || st.gate_control[`HSC_GC_MASS]);
		if (wr_ok) begin
			next_st.wr_ack = 1'b1;
			unique case (REG_ADDR_I)
				`HSC_ADDR_GATE_CONTROL:  next_st.gate_control            = wd;
				`HSC_ADDR_RETRY_POLICY:  next_st.retry_policy            = wd;
				`HSC_ADDR_CURRENT_LIMIT: next_st.current_limit_config    = wd;
				`HSC_ADDR_FET_CHECK:     next_st.fet_check_timing_config = wd;
				`HSC_ADDR_METER_BCAST:   next_st.meter_broadcast_config  = wd;
				`HSC_ADDR_GOOD_PIN_MODE: next_st.power_good_pin_mode     = wd;
				`HSC_ADDR_PIN_OUT_ADC:   next_st.pin_output_adc_rate     = wd;
				`HSC_ADDR_AUX_PIN:       next_st.aux_pin_config          = wd;
				`HSC_ADDR_ADC_SEL_A:     next_st.adc_channel_select_a    = wd;
				`HSC_ADDR_ADC_SEL_B:     next_st.adc_channel_select_b    = wd;
				`HSC_ADDR_FAULT_MASK:    next_st.fault_interrupt_mask    = wd;
				default:                 next_st.wr_ack                  = 1'b0;
			endcase
		end
		if (REG_RD_I) begin
			next_st.rd_valid = 1'b1;
			unique case (REG_ADDR_I)
				`HSC_ADDR_GATE_CONTROL:  next_st.rd_data = st.gate_control;
				`HSC_ADDR_RETRY_POLICY:  next_st.rd_data = st.retry_policy;
				`HSC_ADDR_CURRENT_LIMIT: next_st.rd_data = st.current_limit_config;
				`HSC_ADDR_FET_CHECK:     next_st.rd_data = st.fet_check_timing_config;
				`HSC_ADDR_METER_BCAST:   next_st.rd_data = st.meter_broadcast_config;
				`HSC_ADDR_GOOD_PIN_MODE: next_st.rd_data = st.power_good_pin_mode;
				`HSC_ADDR_PIN_OUT_ADC:   next_st.rd_data = st.pin_output_adc_rate;
				`HSC_ADDR_AUX_PIN:       next_st.rd_data = st.aux_pin_config;
				`HSC_ADDR_ADC_SEL_A:     next_st.rd_data = st.adc_channel_select_a;
				`HSC_ADDR_ADC_SEL_B:     next_st.rd_data = st.adc_channel_select_b;
				`HSC_ADDR_FAULT_MASK:    next_st.rd_data = st.fault_interrupt_mask;
				default:                 next_st.rd_data = 8'h00;
			endcase
		end
	end

	// derived levels from registered state and the GOOD_FUNC_I and LIMIT_ACTIVE_I inputs
	always_comb begin
		adc_code = st.pin_output_adc_rate[`HSC_PO_ADC_HI:`HSC_PO_ADC_LO];
		bc_req   = st.meter_broadcast_config[`HSC_MB_BC_HI:`HSC_MB_BC_LO];
		// slow rates barred at 8 bits, fall back to 512 kbit/s
		next_bc_code = (adc_code == 3'b000 && bc_req[1]) ? 2'b01 : bc_req;
		// cooldown doubles per code step
		next_cool_cyc = 32'(`HSC_COOL_BASE_CYC)
			<< st.fet_check_timing_config[`HSC_FC_COOL_HI:`HSC_FC_COOL_LO];
		// filter delay doubles per code step
		next_filt_cyc = 32'(`HSC_FILT_BASE_CYC)
			<< st.fet_check_timing_config[`HSC_FC_FLT_HI:`HSC_FC_FLT_LO];
		for (int i = 0; i < 4; i++) begin
			unique case (hsc_pin_mode_e'(st.power_good_pin_mode[2*i +: 2]))
				HSC_PG_ACT_LOW: begin
					next_good_pin[i] = !GOOD_FUNC_I[i];
					next_good_oe[i]  = 1'b1;
				end
				HSC_PG_ACT_HIGH: begin
					next_good_pin[i] = GOOD_FUNC_I[i];
					next_good_oe[i]  = 1'b1;
				end
				HSC_PG_GP_OUT: begin
					next_good_pin[i] = st.pin_output_adc_rate[4 + i];
					next_good_oe[i]  = 1'b1;
				end
				HSC_PG_GP_IN: begin
					next_good_pin[i] = 1'b0;
					next_good_oe[i]  = 1'b0;
				end
			endcase
		end
		if (st.gate_control[`HSC_GC_LIMIND]) begin
			next_good_pin[1] = !LIMIT_ACTIVE_I;
			next_good_oe[1]  = 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			st.gate_control            <= `HSC_RST_GATE_CONTROL;
			st.retry_policy            <= `HSC_RST_RETRY_POLICY;
			st.current_limit_config    <= `HSC_RST_CURRENT_LIMIT;
			st.fet_check_timing_config <= `HSC_RST_FET_CHECK;
			st.meter_broadcast_config  <= `HSC_RST_METER_BCAST;
			st.power_good_pin_mode     <= `HSC_RST_GOOD_PIN_MODE;
			st.pin_output_adc_rate     <= `HSC_RST_PIN_OUT_ADC;
			st.aux_pin_config          <= `HSC_RST_AUX_PIN;
			st.adc_channel_select_a    <= `HSC_RST_ADC_SEL_A;
			st.adc_channel_select_b    <= `HSC_RST_ADC_SEL_B;
			st.fault_interrupt_mask    <= `HSC_RST_FAULT_MASK;
			st.rd_data                 <= 8'h00;
			st.rd_valid                <= 1'b0;
			st.wr_ack                  <= 1'b0;
			good_pin                   <= 4'h0;
			good_oe                    <= 4'h0;
			cool_cyc                   <= 32'(`HSC_COOL_BASE_CYC);
			filt_cyc                   <= 32'(`HSC_FILT_BASE_CYC);
			bc_code                    <= 2'b00;
		end else begin
			st       <= next_st;
			good_pin <= next_good_pin;
			good_oe  <= next_good_oe;
			cool_cyc <= next_cool_cyc;
			filt_cyc <= next_filt_cyc;
			bc_code  <= next_bc_code;
		end
	end

	// field decode, all straight from state flip-flops
	always_comb begin
		REG_RDATA_O                 = st.rd_data;
		REG_RVALID_O                = st.rd_valid;
		REG_WACK_O                  = st.wr_ack;
		MASS_WR_EN_O                = st.gate_control[`HSC_GC_MASS];
		PAGE_RW_EN_O                = st.gate_control[`HSC_GC_PAGE];
		GATE_ON_O                   = st.gate_control[`HSC_GC_ON];
		SLOPE_INRUSH_O              = st.gate_control[`HSC_GC_SLOPE];
		TMR_PULLDOWN_OFF_O          = st.gate_control[`HSC_GC_TMR];
		FET_FAULT_SHUTOFF_O         = st.gate_control[`HSC_GC_FETOFF];
		GOOD_CLEAR_BY_VOUT_O        = st.gate_control[`HSC_GC_PGCLR];
		EXT_FAULT_SHUTOFF_O         = st.meter_broadcast_config[`HSC_MB_EXTOFF];
		EXT_FAULT_AUTORETRY_O       = st.retry_policy[`HSC_RP_EXT];
		GOOD_INPUT_AUTORETRY_O      = st.retry_policy[`HSC_RP_PGI];
		UV_AUTORETRY_O              = st.retry_policy[`HSC_RP_UV];
		OV_AUTORETRY_O              = st.retry_policy[`HSC_RP_OV];
		FET_RETRY_LIMIT_O           = retry_limit(st.retry_policy[`HSC_RP_FET_HI:`HSC_RP_FET_LO]);
		OVERCURRENT_RETRY_COUNT_LIMIT_O            = retry_limit(st.retry_policy[`HSC_RP_OC_HI:`HSC_RP_OC_LO]);
		COOLDOWN_CYC_O              = cool_cyc;
		LIMIT_MV_O                  = st.current_limit_config[`HSC_CL_CODE_HI:`HSC_CL_CODE_LO];
		FAST_LIMIT_MV_O             = 6'(6'd30 + {1'b0, st.current_limit_config[7:4], 1'b0});
		FOLDBACK_CODE_O             = st.current_limit_config[`HSC_CL_FB_HI:`HSC_CL_FB_LO];
		POST_STARTUP_FOLDBACK_OFF_O = st.current_limit_config[`HSC_CL_FBOFF];
		LOAD_POWER_FOLDBACK_O       = st.current_limit_config[`HSC_CL_LOAD_POWER_FOLDBACK_ENABLE];
		DRAIN_THRESHOLD_CODE_O      = st.fet_check_timing_config[`HSC_FC_DTH_HI:`HSC_FC_DTH_LO];
		FILTER_CYC_O                = filt_cyc;
		POWER_ON_INDICATOR_O        = st.fet_check_timing_config[`HSC_FC_POR];
		POWER_VOLTAGE_SELECT_O      = st.meter_broadcast_config[`HSC_MB_VSEL];
		BROADCAST_RATE_CODE_O       = bc_code;
		METER_INTEGRATE_CURRENT_O   = st.meter_broadcast_config[`HSC_MB_INTI];
		TICK_OVF_ALERT_EN_O         = st.meter_broadcast_config[`HSC_MB_TICKA];
		METER_OVF_ALERT_EN_O        = st.meter_broadcast_config[`HSC_MB_METERA];
		GOOD_PIN_O                  = good_pin;
		GOOD_PIN_OE_O               = good_oe;
		AUX_PIN_O                   = st.aux_pin_config[3:0];
		AUX_PIN_OE_O                = ~st.aux_pin_config[7:4];
		ADC_INPUT_SELECT_O          = {st.adc_channel_select_b[7:4], st.adc_channel_select_a};
		ADC_BITS_O                  = adc_bits(st.pin_output_adc_rate[2:0]);
		ADC_SAMPLE_DIV_O            = (st.pin_output_adc_rate[2:0] == 3'b000) ? 2'd0 :
		                              (st.pin_output_adc_rate[2:0] == 3'b010) ? 2'd1 : 2'd2;
		FAULT_INTERRUPT_MASK_O      = st.fault_interrupt_mask;
	end

	// assertions
	gate_follows_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		REG_WR_I && !MASS_WR_I && REG_ADDR_I == `HSC_ADDR_GATE_CONTROL
		|=> GATE_ON_O == $past(REG_WDATA_I[7]))
		else $error("gate bit did not follow write");
	slope_follows_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		REG_WR_I && !MASS_WR_I && REG_ADDR_I == `HSC_ADDR_GATE_CONTROL
		|=> SLOPE_INRUSH_O == $past(REG_WDATA_I[6]) && FET_FAULT_SHUTOFF_O == $past(REG_WDATA_I[4]))
		else $error("slope or shutoff bit wrong");
	mass_block_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		REG_WR_I && MASS_WR_I && !MASS_WR_EN_O && REG_ADDR_I == `HSC_ADDR_RETRY_POLICY
		|=> $stable(UV_AUTORETRY_O) && !REG_WACK_O)
		else $error("mass write accepted while disabled");
	retry_seven_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		REG_WR_I && !MASS_WR_I && REG_ADDR_I == `HSC_ADDR_RETRY_POLICY && REG_WDATA_I[3:2] == 2'b10
		|=> OVERCURRENT_RETRY_COUNT_LIMIT_O == 4'h7)
		else $error("overcurrent retry count wrong");
	fast_limit_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		FAST_LIMIT_MV_O == 6'(2 * (15 + LIMIT_MV_O)))
		else $error("fast limit not twice limit");
	cooldown_max_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		st.fet_check_timing_config[3:1] == 3'b111 ##1 st.fet_check_timing_config[3:1] == 3'b111
		|-> COOLDOWN_CYC_O == 32'd2621440000)
		else $error("cooldown code 7 wrong");
	por_clear_a: assert property (@(posedge CLK_I)
		RST_I |=> !POWER_ON_INDICATOR_O && GATE_ON_O)
		else $error("reset defaults wrong");
	bc_slow_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		$past(ADC_BITS_O) == 5'h08 && ADC_BITS_O == 5'h08 && !$past(RST_I) |-> !BROADCAST_RATE_CODE_O[1])
		else $error("slow broadcast at 8 bits");
	aux_dir_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		REG_WR_I && !MASS_WR_I && REG_ADDR_I == `HSC_ADDR_AUX_PIN
		|=> AUX_PIN_OE_O == ~$past(REG_WDATA_I[7:4]))
		else $error("aux direction wrong");
	readback_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		REG_RD_I && !REG_WR_I && REG_ADDR_I == `HSC_ADDR_ADC_SEL_A
		|=> REG_RVALID_O && REG_RDATA_O == ADC_INPUT_SELECT_O[7:0])
		else $error("readback mismatch");
	cov_gate_off_c: cover property (@(posedge CLK_I) $fell(GATE_ON_O));
	cov_mass_c:     cover property (@(posedge CLK_I) REG_WR_I && MASS_WR_I ##1 REG_WACK_O);
	cov_limind_c:   cover property (@(posedge CLK_I) GOOD_PIN_OE_O[1] && st.gate_control[2]);

endmodule : hsc_cfg_regs
`default_nettype wire

// *** dv/hsc_host_model.sv ***
// hsc_host_model: serial bus engine stand-in issuing byte accesses
// assumes: requests launched after a rising edge, answers one cycle later
`timescale 1ns/1ps
`default_nettype none
module hsc_host_model
	import hsc_cfg_pkg::*;
(
	// clock and answers
	input  wire logic      clk_i,
	input  wire logic      wack_i,
	input  wire logic      rvalid_i,
	input  wire hsc_byte_t rdata_i,
	// requests
	output logic           wr_o,
	output logic           rd_o,
	output logic           mass_o,
	output hsc_byte_t      addr_o,
	output hsc_byte_t      wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		mass_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// released address and data lines show the inverse, strobes drop to zero
	task automatic wr(input hsc_byte_t a, input hsc_byte_t d, input logic m, output logic ack);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		mass_o <= m;
		@(posedge clk_i);
		wr_o <= 1'b0;
		mass_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
		#1 ack = wack_i;
	endtask : wr
	task automatic rd(input hsc_byte_t a, output hsc_byte_t d, output logic v);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
		v = rvalid_i;
	endtask : rd
endmodule : hsc_host_model
`default_nettype wire

// *** dv/tb_top.sv ***
// tb_top: self-checking bench of the configuration register bank
// assumes: hsc_host_model issues every register access
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import hsc_cfg_pkg::*;
;
	logic        clk, rst, lim, wr, rd, mass, wack, rv, gon, slope, men, ack;
	logic        pg_en, fso, gclr, efso, efr, gir, uvr, ovr, por;
	logic [4:0]  abits;
	logic [11:0] asel;
	logic [3:0]  gfun, fet, oc, lmv, gp, goe, ap, aoe;
	logic [5:0]  fmv;
	logic [1:0]  bc, fbc;
	logic [31:0] cool, filt;
	hsc_byte_t   addr, wdat, rdat, fmask;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cyc = 0;
	hsc_byte_t   rstv [11] = '{8'hdb, 8'h03, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h04, 8'hf0,
		8'hff, 8'h0f, 8'h00};
	logic [3:0]  lim_tab [4] = '{4'h0, 4'h1, 4'h7, 4'hf};
	hsc_host_model host_u (.clk_i(clk), .wack_i(wack), .rvalid_i(rv), .rdata_i(rdat),
		.wr_o(wr), .rd_o(rd), .mass_o(mass), .addr_o(addr), .wdata_o(wdat));
	hsc_cfg_regs dut_u (.CLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdat), .MASS_WR_I(mass), .REG_RDATA_O(rdat),
		.REG_RVALID_O(rv), .REG_WACK_O(wack), .MASS_WR_EN_O(men), .PAGE_RW_EN_O(pg_en),
		.GATE_ON_O(gon), .SLOPE_INRUSH_O(slope), .TMR_PULLDOWN_OFF_O(),
		.FET_FAULT_SHUTOFF_O(fso), .EXT_FAULT_SHUTOFF_O(efso), .GOOD_CLEAR_BY_VOUT_O(gclr),
		.EXT_FAULT_AUTORETRY_O(efr), .GOOD_INPUT_AUTORETRY_O(gir), .UV_AUTORETRY_O(uvr),
		.OV_AUTORETRY_O(ovr), .FET_RETRY_LIMIT_O(fet), .OVERCURRENT_RETRY_COUNT_LIMIT_O(oc),
		.COOLDOWN_CYC_O(cool), .LIMIT_MV_O(lmv), .FAST_LIMIT_MV_O(fmv),
		.FOLDBACK_CODE_O(fbc), .POST_STARTUP_FOLDBACK_OFF_O(), .LOAD_POWER_FOLDBACK_O(),
		.DRAIN_THRESHOLD_CODE_O(), .FILTER_CYC_O(filt), .POWER_ON_INDICATOR_O(por),
		.POWER_VOLTAGE_SELECT_O(), .BROADCAST_RATE_CODE_O(bc),
		.METER_INTEGRATE_CURRENT_O(), .TICK_OVF_ALERT_EN_O(), .METER_OVF_ALERT_EN_O(),
		.LIMIT_ACTIVE_I(lim), .GOOD_FUNC_I(gfun), .GOOD_PIN_O(gp), .GOOD_PIN_OE_O(goe),
		.AUX_PIN_O(ap), .AUX_PIN_OE_O(aoe), .ADC_INPUT_SELECT_O(asel), .ADC_BITS_O(abits),
		.ADC_SAMPLE_DIV_O(), .FAULT_INTERRUPT_MASK_O(fmask));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrt(input hsc_byte_t a, input hsc_byte_t d);
		host_u.wr(a, d, 1'b0, ack);
		chk(ack, 1);
	endtask : wrt
	task automatic rchk(input hsc_byte_t a, input hsc_byte_t e);
		hsc_byte_t d;
		logic v;
		host_u.rd(a, d, v);
		chk({v, d}, {1'b1, e});
	endtask : rchk
	// lets the one-cycle-late cycle counts land
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		rst = 1'b1;
		lim = 1'b0;
		gfun = 4'h5;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 11; i++) rchk(hsc_byte_t'(10 + i + (i > 1)), rstv[i]);
		chk({gon, men}, 2'b11);
		chk({pg_en, fso, gclr, efr, gir, uvr, ovr}, 7'b1110011);
		chk({efso, por, fbc, abits}, {2'b00, 2'b11, 5'h0c});
		chk({asel, fmask}, 20'h0ff00);
		$display("defaults done");
		wrt(8'h0a, 8'h5b);
		chk({gon, slope}, 2'b01);
		rchk(8'h0a, 8'h5b);
		wrt(8'h0a, 8'h59);
		host_u.wr(8'h0b, 8'h00, 1'b1, ack);
		chk(ack, 0);
		rchk(8'h0b, 8'h03);
		wrt(8'h0a, 8'hdb);
		for (int c = 0; c < 4; c++) begin
			host_u.wr(8'h0b, {2'b00, 2'(c), 2'(c), 2'b11}, 1'b1, ack);
			settle();
			chk({ack, fet, oc}, {1'b1, lim_tab[c], lim_tab[c]});
		end
		for (int c = 0; c < 16; c += 15) begin
			wrt(8'h0d, {4'(c), 4'h0});
			chk({lmv, fmv}, {4'(c), 6'(30 + 2 * c)});
		end
		wrt(8'h0b, 8'ha8);
		chk({efr, gir, uvr, ovr, fet, oc}, {4'b1000, 4'h7, 4'h7});
		$display("retry and limit done");
		wrt(8'h0e, 8'h3f);
		settle();
		chk(cool, `HSC_COOL_BASE_CYC << 7);
		chk(filt, `HSC_FILT_BASE_CYC << 3);
		chk(por, 1'b1);
		rchk(8'h0e, 8'h3f);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		rchk(8'h0e, 8'h00);
		settle();
		chk(cool, `HSC_COOL_BASE_CYC);
		wrt(8'h11, 8'h00);
		chk(abits, 5'h08);
		wrt(8'h0f, 8'h98);
		chk(efso, 1'b1);
		settle();
		chk(bc, 2'b01);
		wrt(8'h11, 8'ha4);
		settle();
		chk(bc, 2'b11);
		chk(abits, 5'h0c);
		$display("timing and broadcast done");
		wrt(8'h10, 8'haa);
		settle();
		chk({goe, gp}, 8'hfa);
		wrt(8'h10, 8'hff);
		settle();
		chk(goe, 4'h0);
		wrt(8'h10, 8'h00);
		settle();
		chk({goe, gp}, 8'hfa);
		wrt(8'h0a, 8'hdf);
		@(posedge clk) lim <= 1'b1;
		settle();
		chk({goe[1], gp[1]}, 2'b10);
		wrt(8'h14, 8'ha5);
		wrt(8'h15, 8'h81);
		chk({asel, fmask}, 20'haff81);
		wrt(8'h12, 8'h35);
		chk({aoe, ap}, 8'hc5);
		host_u.wr(8'h0c, 8'h55, 1'b0, ack);
		chk(ack, 0);
		rchk(8'h0c, 8'h00);
		$display("pins and unmapped done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
